// ### hdl/ssf_crc4.sv
// Four-bit check code over a 16-bit word.
// Assumes nothing; purely combinational.
`default_nettype none
module ssf_crc4 (
    // Word in.
    input  wire logic [15:0] i_data,
    // Code out.
    output logic      [3:0]  o_crc
);
    always_comb
    begin
        logic [3:0] c;
        logic       inv;
        c = ssf_pkg::CRC_SEED;
        inv = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            inv = i_data[i] ^ c[3];
            c = {c[2], c[1], c[0] ^ inv, inv};
        end
        o_crc = c;
    end
endmodule : ssf_crc4
`default_nettype wire

// ### hdl/ssf_dev.sv
// Sensor end: SPI mode 3 slave framing, command decode and byte-paired registers.
// Assumes SPI pins change synchronously to i_clk, well below its rate.
`default_nettype none
module ssf_dev (
    // Link.
    ssf_link_if.dev             link,
    // Clock and reset.
    input  wire logic           i_clk,
    input  wire logic           i_sys_rst,
    // Nonvolatile configuration byte.
    input  wire logic [7:0]     i_nv_cfg,
    // Warning clear.
    input  wire logic           i_warn_clr,
    // Register load from the sensor core.
    input  wire logic           i_ld_we,
    input  wire logic [5:0]     i_ld_addr,
    input  wire logic [7:0]     i_ld_data,
    // Warnings.
    output logic                o_warn_ier,
    output logic                o_warn_crc,
    // Write notification.
    output logic                o_wr_stb,
    output logic      [5:0]     o_wr_addr,
    output logic      [7:0]     o_wr_data
);
    localparam int NREG = 1 << ssf_pkg::ADDR_W;

    logic [7:0]  mem [NREG];
    logic        sclk_q_r;
    logic        sclk_q_nxt;
    logic        cs_q_r;
    logic        cs_q_nxt;
    logic [4:0]  cnt_r;
    logic [4:0]  cnt_nxt;
    logic [20:0] rx_r;
    logic [20:0] rx_nxt;
    logic [20:0] tx_r;
    logic [20:0] tx_nxt;
    logic        miso_r;
    logic        miso_nxt;
    logic        oe_n_r;
    logic        oe_n_nxt;
    logic [15:0] rd_r;
    logic [15:0] rd_nxt;
    logic        ier_r;
    logic        ier_nxt;
    logic        crcw_r;
    logic        crcw_nxt;
    logic        wstb_r;
    logic        wstb_nxt;
    logic [5:0]  waddr_r;
    logic [5:0]  waddr_nxt;
    logic [7:0]  wdata_r;
    logic [7:0]  wdata_nxt;
    logic        mem_we;
    logic [5:0]  mem_addr;
    logic [7:0]  mem_data;
    logic [3:0]  tx_crc;
    logic [3:0]  rx_crc;
    logic [15:0] cmd;
    logic [3:0]  cmd_crc;
    logic [5:0]  cmd_addr;
    logic        sel;
    logic        fr_start;
    logic        fr_end;
    logic        rise;
    logic        fall;
    logic        legal;
    logic        has_crc;
    logic        extra;
    logic        bad_crc;
    logic        s17_en;
    logic        chk_en;

    ssf_crc4 u_tx_crc (
        .i_data (rd_r),
        .o_crc  (tx_crc)
    );

    ssf_crc4 u_rx_crc (
        .i_data (cmd),
        .o_crc  (rx_crc)
    );

    assign s17_en = i_nv_cfg[ssf_pkg::NV_S17_BIT];
    assign chk_en = i_nv_cfg[ssf_pkg::NV_CHK_BIT];
    assign sel = ~link.cs_n;
    assign fr_start = cs_q_r & ~link.cs_n;
    assign fr_end = ~cs_q_r & link.cs_n;
    assign rise = sel & ~cs_q_r & link.sclk & ~sclk_q_r;
    assign fall = sel & ~cs_q_r & ~link.sclk & sclk_q_r;
    assign cmd_addr = cmd[ssf_pkg::CMD_ADDR_LSB +: ssf_pkg::ADDR_W];

    // Frame length is only known once chip select returns high.
    always_comb
    begin
        cmd = rx_r[15:0];
        cmd_crc = 4'h0;
        legal = 1'b0;
        has_crc = 1'b0;
        extra = 1'b0;
        case (cnt_r)
            5'(ssf_pkg::FRM_STD):
            begin
                legal = 1'b1;
            end
            5'(ssf_pkg::FRM_S17):
            begin
                cmd = rx_r[16:1];
                legal = s17_en;
                extra = ~s17_en;
            end
            5'(ssf_pkg::FRM_CRC):
            begin
                cmd = rx_r[19:4];
                cmd_crc = rx_r[3:0];
                legal = 1'b1;
                has_crc = 1'b1;
            end
            5'(ssf_pkg::FRM_SHR):
            begin
                cmd = rx_r[20:5];
                cmd_crc = rx_r[4:1];
                legal = 1'b1;
                has_crc = 1'b1;
            end
            default:
            begin
                extra = (cnt_r > 5'(ssf_pkg::FRM_STD));
            end
        endcase
        bad_crc = has_crc & chk_en & (rx_crc != cmd_crc);
    end

    always_comb
    begin
        sclk_q_nxt = link.sclk;
        cs_q_nxt = link.cs_n;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        miso_nxt = miso_r;
        oe_n_nxt = oe_n_r;
        rd_nxt = rd_r;
        wstb_nxt = 1'b0;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        ier_nxt = ier_r & ~i_warn_clr;
        crcw_nxt = crcw_r & ~i_warn_clr;
        mem_we = i_ld_we;
        mem_addr = i_ld_addr;
        mem_data = i_ld_data;
        if (fr_start)
        begin
            cnt_nxt = 5'h00;
            rx_nxt = 21'h000000;
            tx_nxt = {rd_r, tx_crc, tx_crc[3]};
            miso_nxt = rd_r[15];
            oe_n_nxt = 1'b0;
        end
        if (fall)
        begin
            miso_nxt = tx_r[20];
            tx_nxt = {tx_r[19:0], 1'b0};
        end
        if (rise)
        begin
            rx_nxt = {rx_r[19:0], link.mosi};
            cnt_nxt = (cnt_r == 5'h1f) ? cnt_r : 5'(cnt_r + 5'h01);
        end
        if (fr_end)
        begin
            oe_n_nxt = 1'b1;
            if (extra)
            begin
                ier_nxt = 1'b1;
            end
            if (legal & bad_crc)
            begin
                crcw_nxt = 1'b1;
            end
            else if (legal & ~cmd[ssf_pkg::CMD_LEAD_BIT])
            begin
                if (cmd[ssf_pkg::CMD_DIR_BIT])
                begin
                    mem_we = 1'b1;
                    mem_addr = cmd_addr;
                    mem_data = cmd[7:0];
                    wstb_nxt = 1'b1;
                    waddr_nxt = cmd_addr;
                    wdata_nxt = cmd[7:0];
                end
                else if (cmd_addr == 6'h00)
                begin
                    rd_nxt = 16'h0000;
                end
                else if (cmd_addr[0])
                begin
                    rd_nxt = {8'h00, mem[cmd_addr]};
                end
                else
                begin
                    rd_nxt = {mem[cmd_addr], mem[cmd_addr | 6'h01]};
                end
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            sclk_q_r <= 1'b1;
            cs_q_r <= 1'b1;
            cnt_r <= 5'h00;
            rx_r <= 21'h000000;
            tx_r <= 21'h000000;
            miso_r <= 1'b1;
            oe_n_r <= 1'b1;
            rd_r <= 16'h0000;
            ier_r <= 1'b0;
            crcw_r <= 1'b0;
            wstb_r <= 1'b0;
            waddr_r <= 6'h00;
            wdata_r <= 8'h00;
        end
        else
        begin
            sclk_q_r <= sclk_q_nxt;
            cs_q_r <= cs_q_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            miso_r <= miso_nxt;
            oe_n_r <= oe_n_nxt;
            rd_r <= rd_nxt;
            ier_r <= ier_nxt;
            crcw_r <= crcw_nxt;
            wstb_r <= wstb_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    // Register contents survive reset; only the core or the link writes them.
    always_ff @(posedge i_clk)
    begin
        if (mem_we)
        begin
            mem[mem_addr] <= mem_data;
        end
    end

    assign link.miso_drv = miso_r;
    assign link.miso_oe_n = oe_n_r;
    assign o_warn_ier = ier_r;
    assign o_warn_crc = crcw_r;
    assign o_wr_stb = wstb_r;
    assign o_wr_addr = waddr_r;
    assign o_wr_data = wdata_r;
endmodule : ssf_dev
`default_nettype wire

// ### hdl/ssf_host.sv
// Host end: SPI mode 3 master driven through APB registers.
// Assumes APB runs on i_clk; SCLK is divided down from it.
`default_nettype none
module ssf_host #(
    parameter logic [7:0] HALF = ssf_pkg::HALF_CYC
) (
    // Link.
    ssf_link_if.host            link,
    // Clock and reset.
    input  wire logic           i_clk,
    input  wire logic           i_sys_rst,
    // APB slave.
    input  wire logic           i_psel,
    input  wire logic           i_penable,
    input  wire logic           i_pwrite,
    input  wire logic [7:0]     i_paddr,
    input  wire logic [31:0]    i_pwdata,
    output logic      [31:0]    o_prdata,
    output logic                o_pready,
    output logic                o_pslverr
);
    ssf_pkg::ssf_hst_t  st_r, st_nxt;
    ssf_pkg::ssf_mode_t mode_r, mode_nxt;
    logic [7:0]  tmr_r, tmr_nxt;
    logic [4:0]  bit_r, bit_nxt;
    logic [15:0] cmd_r, cmd_nxt;
    logic [20:0] tx_r, tx_nxt;
    logic [20:0] rx_r, rx_nxt;
    logic [19:0] rxd_r, rxd_nxt;
    logic        done_r, done_nxt;
    logic        cerr_r, cerr_nxt;
    logic        cs_n_r, cs_n_nxt;
    logic        sclk_r, sclk_nxt;
    logic        mosi_r, mosi_nxt;
    logic        rdy_r, rdy_nxt;
    logic        serr_r, serr_nxt;
    logic [31:0] prd_r, prd_nxt;
    logic [3:0]  cmd_crc;
    logic [3:0]  got_crc;
    logic [19:0] got;
    logic        wr;
    logic        hit;

    ssf_crc4 u_cmd_crc (
        .i_data (cmd_r),
        .o_crc  (cmd_crc)
    );

    ssf_crc4 u_got_crc (
        .i_data (got[19:4]),
        .o_crc  (got_crc)
    );

    always_comb
    begin
        case (mode_r)
            ssf_pkg::MODE_20: got = rx_r[19:0];
            ssf_pkg::MODE_21: got = rx_r[20:1];
            default: got = {rx_r[15:0], 4'h0};
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        mode_nxt = mode_r;
        tmr_nxt = (tmr_r == 8'h00) ? tmr_r : 8'(tmr_r - 8'h01);
        bit_nxt = bit_r;
        cmd_nxt = cmd_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        rxd_nxt = rxd_r;
        done_nxt = done_r;
        cerr_nxt = cerr_r;
        cs_n_nxt = cs_n_r;
        sclk_nxt = sclk_r;
        mosi_nxt = mosi_r;
        wr = i_psel & i_penable & rdy_r & i_pwrite;
        hit = (i_paddr == ssf_pkg::REG_CTRL) | (i_paddr == ssf_pkg::REG_CMD)
            | (i_paddr == ssf_pkg::REG_STAT) | (i_paddr == ssf_pkg::REG_RXD);
        rdy_nxt = i_psel & i_penable & ~rdy_r;
        serr_nxt = i_psel & i_penable & ~rdy_r & ~hit;
        prd_nxt = 32'h00000000;
        case (i_paddr)
            ssf_pkg::REG_CTRL: prd_nxt = 32'({mode_r, 1'b0});
            ssf_pkg::REG_CMD: prd_nxt = 32'(cmd_r);
            ssf_pkg::REG_STAT: prd_nxt = 32'({cerr_r, done_r, st_r != ssf_pkg::H_IDLE});
            ssf_pkg::REG_RXD: prd_nxt = 32'(rxd_r);
            default: prd_nxt = 32'h00000000;
        endcase
        if (wr & (i_paddr == ssf_pkg::REG_CMD) & (st_r == ssf_pkg::H_IDLE))
        begin
            cmd_nxt = i_pwdata[15:0];
        end
        if (wr & (i_paddr == ssf_pkg::REG_STAT) & i_pwdata[ssf_pkg::STAT_DONE_BIT])
        begin
            done_nxt = 1'b0;
        end
        case (st_r)
            ssf_pkg::H_IDLE:
            begin
                if (wr & (i_paddr == ssf_pkg::REG_CTRL) & i_pwdata[ssf_pkg::CTRL_START_BIT])
                begin
                    mode_nxt = ssf_pkg::ssf_mode_t'(i_pwdata[ssf_pkg::CTRL_MODE_LSB +: 2]);
                    tx_nxt = {cmd_r, i_pwdata[ssf_pkg::CTRL_MODE_LSB + 1] ? cmd_crc : 4'h0, 1'b0};
                    rx_nxt = 21'h000000;
                    bit_nxt = 5'h00;
                    cs_n_nxt = 1'b0;
                    tmr_nxt = 8'(ssf_pkg::CS_CYC - 8'h01);
                    st_nxt = ssf_pkg::H_LEAD;
                end
            end
            ssf_pkg::H_LEAD,
            ssf_pkg::H_HIGH:
            begin
                if (tmr_r == 8'h00)
                begin
                    if (st_r == ssf_pkg::H_HIGH && bit_r == ssf_pkg::frame_bits(mode_r))
                    begin
                        tmr_nxt = 8'(ssf_pkg::CHD_CYC - 8'h01);
                        st_nxt = ssf_pkg::H_TAIL;
                    end
                    else
                    begin
                        // Falling edge: data changes, late sampling catches the previous bit.
                        sclk_nxt = 1'b0;
                        mosi_nxt = tx_r[20];
                        tx_nxt = {tx_r[19:0], 1'b0};
                        if (mode_r == ssf_pkg::MODE_17 && bit_r != 5'h00)
                        begin
                            rx_nxt = {rx_r[19:0], link.miso};
                        end
                        tmr_nxt = 8'(HALF - 8'h01);
                        st_nxt = ssf_pkg::H_LOW;
                    end
                end
            end
            ssf_pkg::H_LOW:
            begin
                if (tmr_r == 8'h00)
                begin
                    sclk_nxt = 1'b1;
                    if (mode_r != ssf_pkg::MODE_17)
                    begin
                        rx_nxt = {rx_r[19:0], link.miso};
                    end
                    bit_nxt = 5'(bit_r + 5'h01);
                    tmr_nxt = 8'(HALF - 8'h01);
                    st_nxt = ssf_pkg::H_HIGH;
                end
            end
            ssf_pkg::H_TAIL:
            begin
                if (tmr_r == 8'h00)
                begin
                    cs_n_nxt = 1'b1;
                    rxd_nxt = got;
                    done_nxt = 1'b1;
                    cerr_nxt = mode_r[1] & (got_crc != got[3:0]);
                    tmr_nxt = 8'(ssf_pkg::IDLE_CYC - 8'h01);
                    st_nxt = ssf_pkg::H_GAP;
                end
            end
            ssf_pkg::H_GAP:
            begin
                if (tmr_r == 8'h00)
                begin
                    st_nxt = ssf_pkg::H_IDLE;
                end
            end
            default:
            begin
                st_nxt = ssf_pkg::H_IDLE;
                cs_n_nxt = 1'b1;
                sclk_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_r <= ssf_pkg::H_IDLE;
            mode_r <= ssf_pkg::ssf_mode_t'(ssf_pkg::MODE_RST);
            tmr_r <= 8'h00;
            bit_r <= 5'h00;
            cmd_r <= ssf_pkg::CMD_RST;
            tx_r <= 21'h000000;
            rx_r <= 21'h000000;
            rxd_r <= 20'h00000;
            done_r <= 1'b0;
            cerr_r <= 1'b0;
            cs_n_r <= 1'b1;
            sclk_r <= 1'b1;
            mosi_r <= 1'b0;
            rdy_r <= 1'b0;
            serr_r <= 1'b0;
            prd_r <= 32'h00000000;
        end
        else
        begin
            st_r <= st_nxt;
            mode_r <= mode_nxt;
            tmr_r <= tmr_nxt;
            bit_r <= bit_nxt;
            cmd_r <= cmd_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            rxd_r <= rxd_nxt;
            done_r <= done_nxt;
            cerr_r <= cerr_nxt;
            cs_n_r <= cs_n_nxt;
            sclk_r <= sclk_nxt;
            mosi_r <= mosi_nxt;
            rdy_r <= rdy_nxt;
            serr_r <= serr_nxt;
            prd_r <= prd_nxt;
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.sclk = sclk_r;
    assign link.mosi = mosi_r;
    assign o_prdata = prd_r;
    assign o_pready = rdy_r;
    assign o_pslverr = serr_r;
endmodule : ssf_host
`default_nettype wire

// ### hdl/ssf_link_if.sv
// SPI link between the sensor end and the host end.
// Assumes MISO is pulled high while the sensor does not drive it.
`default_nettype none
interface ssf_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_drv;
    logic miso_oe_n;
    wire  miso;

    assign miso = miso_oe_n ? 1'b1 : miso_drv;

    modport dev (input cs_n, input sclk, input mosi, output miso_drv, output miso_oe_n);
    modport host (output cs_n, output sclk, output mosi, input miso);
endinterface : ssf_link_if
`default_nettype wire

// ### hdl/ssf_pkg.sv
// Shared constants, types and helpers of the sensor SPI framing ends.
// Assumes both ends run on one 100 MHz clock and meet through ssf_link_if.
//
// Operation
// - Clock idles high; capture rising, change falling.
// - Frames carry 16, 17, 20 or 21 bits.
// - 17-bit frame legal only if enabled.
// - Extra clock pulses set interface error warning.
// - Clean legal frames never set that warning.
// - Falling-edge sampling host uses 17-bit frames.
// - Shared-bus host uses 21-bit frames.
// - 21st host bit is zero, content shifted left.
// - 21-bit frame repeats check-code MSB last.
// - Command: zero, write flag, address, data, check.
// - Full register write needs even and odd writes.
// - Device samples MOSI on rising SCLK.
// - Read result returns in the next frame.
// - New read accepted while returning previous result.
// - All-zero frame reads register zero as zero.
// - Host captures MISO in every frame, read or not.
// - Even address returns even and odd byte.
// - Odd address returns one byte, upper zero.
// - Beyond 16 bits the device appends check code.
// - Check code x^4+x+1, preset ones, MSB first.
// - Wrong inbound check code discards frame, warns.
`default_nettype none
package ssf_pkg;
    localparam int FRM_STD = 16;
    localparam int FRM_S17 = 17;
    localparam int FRM_CRC = 20;
    localparam int FRM_SHR = 21;
    localparam logic [3:0] CRC_SEED = 4'hf;
    localparam int ADDR_W = 6;
    localparam int CMD_LEAD_BIT = 15;
    localparam int CMD_DIR_BIT = 14;
    localparam int CMD_ADDR_LSB = 8;
    localparam int NV_CHK_BIT = 0;
    localparam int NV_S17_BIT = 1;
    // Host registers reached over APB.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_RXD = 8'h0c;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_CRCERR_BIT = 2;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [15:0] CMD_RST = 16'h0000;
    // Timing, in ns and in 10 ns cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_HALF_NS = 50;
    localparam int T_CS_NS = 50;
    localparam int T_CS_IDLE_NS = 200;
    localparam int T_CHD_NS = 5;

    function automatic int cdiv(input int num, input int den);
        int q;
        q = (num + den - 1) / den;
        return (q < 1) ? 1 : q;
    endfunction : cdiv

    localparam logic [7:0] HALF_CYC = 8'(cdiv(T_HALF_NS, CLK_PERIOD_NS));
    localparam logic [7:0] CS_CYC = 8'(cdiv(T_CS_NS, CLK_PERIOD_NS));
    localparam logic [7:0] IDLE_CYC = 8'(cdiv(T_CS_IDLE_NS, CLK_PERIOD_NS));
    localparam logic [7:0] CHD_CYC = 8'(cdiv(T_CHD_NS, CLK_PERIOD_NS));

    typedef enum logic [1:0] {
        MODE_16 = 2'h0,
        MODE_17 = 2'h1,
        MODE_20 = 2'h2,
        MODE_21 = 2'h3
    } ssf_mode_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LEAD = 3'h1,
        H_LOW  = 3'h3,
        H_HIGH = 3'h2,
        H_TAIL = 3'h6,
        H_GAP  = 3'h4
    } ssf_hst_t;

    function automatic logic [4:0] frame_bits(input ssf_mode_t m);
        case (m)
            MODE_16: return 5'(FRM_STD);
            MODE_17: return 5'(FRM_S17);
            MODE_20: return 5'(FRM_CRC);
            default: return 5'(FRM_SHR);
        endcase
    endfunction : frame_bits
endpackage : ssf_pkg
`default_nettype wire

// ### tb/ssf_link_chk.sv
// Assertions on the SPI link between the sensor end and the host end.
// Assumes host HALF of 5 cycles and signals taken from ssf_link_if.
`default_nettype none
module ssf_link_chk (
    // Clock and reset.
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    // Link.
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic miso_drv,
    input  wire logic miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] nfall_r;
    logic       c3_r;
    logic       c3_nxt;
    logic [4:0] nfall_nxt;
    logic       sclk_r;
    logic       sclk_nxt;

    // Falls are counted, since each one launches one bit.
    always_comb
    begin
        sclk_nxt = sclk;
        c3_nxt = (nfall_r == 5'h11) ? miso_drv : c3_r;
        nfall_nxt = nfall_r;
        if (cs_n)
            nfall_nxt = 5'h00;
        else if (sclk_r && !sclk)
            nfall_nxt = nfall_r + 5'h01;
    end

    always_ff @(posedge i_clk)
    begin
        sclk_r <= sclk_nxt;
        c3_r <= c3_nxt;
        nfall_r <= nfall_nxt;
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    idle_high_a: assert property (cs_n |-> sclk)
        else $error("clock low while deselected");
    mosi_hold_a: assert property ($rose(sclk) |-> $stable(mosi))
        else $error("mosi moved at capture edge");
    miso_fall_a: assert property (!cs_n && !$past(miso_oe_n) && $changed(miso_drv) |-> !sclk)
        else $error("miso moved while clock high");
    oe_on_a: assert property ($fell(cs_n) |-> ##[1:3] !miso_oe_n)
        else $error("miso not driven after select");
    oe_off_a: assert property ($rose(cs_n) |-> ##[0:3] miso_oe_n)
        else $error("miso not released after frame");
    lead_time_a: assert property ($fell(cs_n) |-> sclk [*5])
        else $error("first fall too early");
    half_low_a: assert property ($fell(sclk) |-> (!sclk) [*5] ##1 sclk)
        else $error("clock low phase wrong");
    tail_high_a: assert property ($rose(cs_n) |-> $past(sclk))
        else $error("clock low before deselect");
    gap_idle_a: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("frame gap too short");
    frame_len_a: assert property ($rose(cs_n) |-> nfall_r inside {5'h10, 5'h11, 5'h14, 5'h15})
        else $error("illegal frame length");
    rep_msb_a: assert property (nfall_r == 5'h15 |-> miso_drv == c3_r)
        else $error("check-code msb not repeated");

    cover property ($rose(cs_n) && nfall_r == 5'h10);
    cover property ($rose(cs_n) && nfall_r == 5'h14);
    cover property ($rose(cs_n) && nfall_r == 5'h15);
endmodule : ssf_link_chk
`default_nettype wire

// ### tb/tb_top.sv
// Testbench joining the sensor end and the host end over ssf_link_if.
// Assumes APB host registers and timing as given in ssf_pkg.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  nv_cfg = 8'h00;
    logic        warn_clr = 1'b0;
    logic        ld_we = 1'b0;
    logic [5:0]  ld_addr = 6'h00;
    logic [7:0]  ld_data = 8'h00;
    logic        ier;
    logic        crc_err;
    logic        wr_stb;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    int          err_count = 0;
    int          n_checks = 0;
    int          n_stb = 0;
    logic [31:0] rx;

    ssf_link_if ssf_link_if_inst ();
    ssf_dev ssf_dev_inst (.link(ssf_link_if_inst.dev), .i_clk(clk), .i_sys_rst(rst), .i_nv_cfg(nv_cfg),
        .i_warn_clr(warn_clr), .i_ld_we(ld_we), .i_ld_addr(ld_addr), .i_ld_data(ld_data), .o_warn_ier(ier),
        .o_warn_crc(crc_err), .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    ssf_host ssf_host_inst (.link(ssf_link_if_inst.host), .i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr));
    ssf_link_chk ssf_link_chk_inst (.i_clk(clk), .i_sys_rst(rst), .cs_n(ssf_link_if_inst.cs_n),
        .sclk(ssf_link_if_inst.sclk), .mosi(ssf_link_if_inst.mosi), .miso_drv(ssf_link_if_inst.miso_drv),
        .miso_oe_n(ssf_link_if_inst.miso_oe_n));

    always #5 clk = ~clk;
    always @(posedge clk) if (wr_stb === 1'b1) n_stb++;

    // Expected code is rebuilt here bit by bit, never borrowed from the design.
    function automatic logic [31:0] exp_rx(input logic [15:0] d);
        logic [3:0] c;
        logic       x;
        c = 4'hf;
        for (int i = 15; i >= 0; i--)
        begin
            x = d[i] ^ c[3];
            c = {c[2], c[1], c[0] ^ x, x};
        end
        return {12'h000, d, c};
    endfunction : exp_rx

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic bail(input string what);
        err_count++;
        $display("[FAIL] %0t timeout in %s", $time, what);
        tally_and_finish();
    endtask : bail

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            bail("apb");
        q = prdata;
        chk(pslverr, 32'(a > ssf_pkg::REG_RXD), "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic frame(input ssf_pkg::ssf_mode_t m, input logic [15:0] cmd, output logic [31:0] r);
        logic [31:0] q;
        int          n;
        apb(1'b1, ssf_pkg::REG_CMD, {16'h0000, cmd}, q);
        apb(1'b1, ssf_pkg::REG_CTRL, {29'h0, m, 1'b1}, q);
        n = 0;
        do
        begin
            apb(1'b0, ssf_pkg::REG_STAT, 32'h0, q);
            n++;
        end while ((q[1] !== 1'b1 || q[0] !== 1'b0) && n < 200);
        if (n >= 200)
            bail("frame");
        chk(q[2], 32'h0, "host code error");
        apb(1'b1, ssf_pkg::REG_STAT, 32'h2, q);
        apb(1'b0, ssf_pkg::REG_RXD, 32'h0, r);
    endtask : frame

    task automatic t_write;
        int s;
        s = n_stb;
        frame(ssf_pkg::MODE_16, 16'h6677, rx);
        chk(n_stb - s, 32'h1, "write strobes");
        chk(wr_addr, 32'h26, "write addr");
        chk(wr_data, 32'h77, "write data");
        frame(ssf_pkg::MODE_16, 16'h6788, rx);
        frame(ssf_pkg::MODE_20, 16'h2600, rx);
        frame(ssf_pkg::MODE_20, 16'h0000, rx);
        chk(rx, exp_rx(16'h7788), "paired readback");
        $display("t_write done");
    endtask : t_write

    task automatic t_read;
        @(posedge clk);
        nv_cfg <= 8'h01;
        frame(ssf_pkg::MODE_20, 16'h2400, rx);
        frame(ssf_pkg::MODE_20, 16'h2500, rx);
        chk(rx, exp_rx(16'ha53c), "even read");
        frame(ssf_pkg::MODE_20, 16'h0000, rx);
        chk(rx, exp_rx(16'h003c), "odd read");
        frame(ssf_pkg::MODE_21, 16'h0000, rx);
        chk(rx, exp_rx(16'h0000), "zero read");
        chk(crc_err, 32'h0, "good code flagged");
        chk(ier, 32'h0, "clean frames flagged");
        $display("t_read done");
    endtask : t_read

    task automatic t_warn;
        @(posedge clk);
        nv_cfg <= 8'h00;
        frame(ssf_pkg::MODE_17, 16'h0000, rx);
        chk(ier, 32'h1, "17 bits not flagged");
        @(posedge clk);
        warn_clr <= 1'b1;
        nv_cfg <= 8'h02;
        @(posedge clk);
        warn_clr <= 1'b0;
        frame(ssf_pkg::MODE_21, 16'h2400, rx);
        chk(ier, 32'h0, "21 bits flagged");
        frame(ssf_pkg::MODE_17, 16'h0000, rx);
        chk(ier, 32'h0, "enabled 17 flagged");
        chk(rx, 32'h000a53c0, "late sampled read");
        $display("t_warn done");
    endtask : t_warn

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        ld_we <= 1'b1;
        ld_addr <= 6'h24;
        ld_data <= 8'ha5;
        @(posedge clk);
        ld_addr <= 6'h25;
        ld_data <= 8'h3c;
        @(posedge clk);
        ld_we <= 1'b0;
        chk(ssf_link_if_inst.miso, 32'h1, "miso idle");
        apb(1'b0, 8'h10, 32'h0, rx);
        chk(rx, 32'h0, "unmapped read");
        t_write();
        t_read();
        t_warn();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
